// *** tb/rcc_baseband_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcc_baseband_model (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// output clock enable of the chain
	input  wire logic        sample_en_in,
	output logic      [31:0] n_samples_out
);
	// captures a sample only on enabled cycles, as the processor would
	logic [31:0] count_ff, nxt_count;
	assign n_samples_out = count_ff;
	always_comb nxt_count = count_ff + {31'h0, sample_en_in};
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			count_ff <= 32'h0;
		else
			count_ff <= nxt_count;
	end
endmodule
`default_nettype wire

// *** tb/rcc_rx_chain_control_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcc_rx_chain_control_sva
	import rcc_pkg::*;
(
	// clock and reset
	input wire logic                  mclk_in,
	input wire logic                  rst_n_in,
	// register port
	input wire logic [RCC_ADDR_W-1:0] reg_addr_in,
	input wire logic [RCC_DATA_W-1:0] reg_wdata_in,
	input wire logic                  reg_wr_in,
	input wire logic                  reg_rd_in,
	input wire logic [RCC_DATA_W-1:0] reg_rdata_out,
	// chain side
	input wire logic                  align_pin_in,
	input wire logic                  other_features_on_in,
	input wire rcc_cfg_t              chain_cfg_out,
	input wire rcc_align_t            align_pulse_out,
	input wire logic [1:0]            mixer_phase_out,
	input wire logic                  divider_phase_out,
	input wire logic                  out_clk_en_out
);
	// shadow of 0x165..0x169; quiet counts settled cycles, so changes get time to land
	logic [4:0][7:0] sh_ff, nxt_sh;
	logic [1:0]      quiet_ff, nxt_quiet;
	logic            feat_ff;
	logic            q_ok, feat;
	assign q_ok = quiet_ff == 2'h3;
	assign feat = (sh_ff[0][0] & sh_ff[0][1]) | sh_ff[1][0] | other_features_on_in;
	always_comb begin
		nxt_sh = sh_ff;
		if (reg_wr_in && reg_addr_in >= RCC_FILTER_LOOPBACK_CTRL
			&& reg_addr_in <= RCC_ALIGN_SOURCE_SELECT)
			nxt_sh[3'(reg_addr_in - RCC_FILTER_LOOPBACK_CTRL)] = reg_wdata_in;
		nxt_quiet = quiet_ff + {1'b0, quiet_ff != 2'h3};
		if (reg_wr_in || other_features_on_in != feat_ff)
			nxt_quiet = 2'h0;
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sh_ff    <= '0;
			quiet_ff <= 2'h0;
		end else begin
			sh_ff    <= nxt_sh;
			quiet_ff <= nxt_quiet;
		end
		feat_ff <= other_features_on_in;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence pin_rise;
		!align_pin_in ##1 align_pin_in;
	endsequence
	sequence all_aligned;
		##[0:2] align_pulse_out == 4'hf;
	endsequence
	decim_gate_a: assert property (q_ok |-> chain_cfg_out.decim_active == &sh_ff[0][1:0])
		else $error("decimation enable not gated");
	filter_mode_a: assert property (q_ok |->
		{chain_cfg_out.chan_a_highpass, chain_cfg_out.chan_b_highpass} == {sh_ff[0][2], sh_ff[0][3]})
		else $error("filter mode wrong");
	loopback_gate_a: assert property (q_ok |-> chain_cfg_out.loopback_sel == &sh_ff[0][7:6])
		else $error("loopback select wrong");
	mixer_mode_a: assert property (q_ok |->
		chain_cfg_out.mixer_mode == (sh_ff[1][0] ? sh_ff[1][2:1] : 2'h0))
		else $error("mixer mode wrong");
	chain_off_a: assert property (q_ok && sh_ff[2][0] |-> chain_cfg_out.chain_off
		&& chain_cfg_out.chan_a_midcode && chain_cfg_out.chan_b_midcode)
		else $error("chain disable not applied");
	chan_a_down_a: assert property (q_ok && !sh_ff[2][0] |-> chain_cfg_out.chan_a_midcode
		== (&sh_ff[2][2:1] & (feat | &sh_ff[2][4:1])))
		else $error("channel a power-down wrong");
	bypass_gate_a: assert property (q_ok |-> chain_cfg_out.bypass == &sh_ff[2][6:5])
		else $error("bypass wrong");
	half_rate_a: assert property (q_ok && chain_cfg_out.decim_active
		|-> out_clk_en_out != $past(out_clk_en_out))
		else $error("output clock not halved");
	full_rate_a: assert property (q_ok && !chain_cfg_out.decim_active |-> out_clk_en_out)
		else $error("output clock stopped");
	global_align_a: assert property (pin_rise ##0 (!sh_ff[3][4] && !sh_ff[4][4])
		|-> all_aligned)
		else $error("pin rise did not align all blocks");
	read_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
endmodule
bind rcc_rx_chain_control rcc_rx_chain_control_sva rcc_rx_chain_control_sva_inst (
	.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.align_pin_in, .other_features_on_in, .chain_cfg_out, .align_pulse_out, .mixer_phase_out,
	.divider_phase_out, .out_clk_en_out
);
`default_nettype wire

// *** tb/rx_chain_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_chain_control_bench;
	import rcc_pkg::*;
	logic        mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic        align_pin_in = 1'b0, other_features_on_in = 1'b0;
	logic [8:0]  reg_addr_in = 9'h000;
	logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out;
	rcc_cfg_t    chain_cfg_out;
	rcc_align_t  align_pulse_out;
	logic [1:0]  mixer_phase_out;
	logic        divider_phase_out, out_clk_en_out;
	logic [31:0] n_samples;
	int unsigned n_fail = 0, comparisons = 0;
	logic [8:0]  ta [5] = '{9'h165, 9'h167, 9'h168, 9'h169, 9'h100};
	logic [7:0]  te [5] = '{8'hcf, 8'h7f, 8'h1f, 8'h1f, 8'h00};
	logic        pf [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0]  pv [5] = '{8'h06, 8'h1e, 8'h06, 8'h04, 8'h01};
	logic [2:0]  pe [5] = '{3'h0, 3'h3, 3'h2, 3'h0, 3'h7};
	always #50 mclk_in = ~mclk_in;
	rcc_rx_chain_control rcc_rx_chain_control_inst (.mclk_in, .rst_n_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .align_pin_in,
		.other_features_on_in, .chain_cfg_out, .align_pulse_out, .mixer_phase_out,
		.divider_phase_out, .out_clk_en_out);
	rcc_baseband_model rcc_baseband_model_inst (.mclk_in, .rst_n_in,
		.sample_en_in(out_clk_en_out), .n_samples_out(n_samples));
	task automatic tally_and_finish();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in    <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in   <= 1'b0;
		@(negedge mclk_in);
		cmp(reg_rdata_out, exp);
	endtask
	// write, then let the registered config land before looking
	task automatic ws(input logic [8:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask
	task automatic rate(input logic [7:0] exp);
		logic [31:0] n0;
		n0 = n_samples;
		repeat (20) @(posedge mclk_in);
		// look off the edge so the model's count for the last edge has settled
		@(negedge mclk_in);
		cmp(8'(n_samples - n0), exp);
	endtask
	task automatic pulse(input logic [3:0] exp);
		int i;
		for (i = 0; i < 6; i++) begin
			@(negedge mclk_in);
			if (align_pulse_out !== 4'h0)
				break;
		end
		cmp({4'h0, align_pulse_out}, {4'h0, exp});
		if (i == 6)
			tally_and_finish();
	endtask
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (int k = 0; k < 6; k++)
			rd(RCC_FILTER_LOOPBACK_CTRL + 9'(k), RCC_REG_RESET);
		foreach (ta[k]) begin
			wr(ta[k], 8'hff);
			rd(ta[k], te[k]);
			wr(ta[k], 8'h00);
		end
		ws(RCC_FILTER_LOOPBACK_CTRL, 8'h01);
		cmp(chain_cfg_out.decim_active, 1'b0);
		ws(RCC_FILTER_LOOPBACK_CTRL, 8'h8f);
		cmp({chain_cfg_out.decim_active, chain_cfg_out.chan_a_highpass,
			chain_cfg_out.chan_b_highpass, chain_cfg_out.loopback_sel}, 8'he);
		rate(8'd10);
		ws(RCC_FILTER_LOOPBACK_CTRL, 8'hc0);
		cmp({chain_cfg_out.decim_active, chain_cfg_out.loopback_sel}, 8'h1);
		ws(RCC_FILTER_LOOPBACK_CTRL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			ws(RCC_MIXER_DIVIDER_CTRL, 8'(2 * k + 1));
			cmp({chain_cfg_out.mixer_active, chain_cfg_out.mixer_mode}, 8'(4 + k));
		end
		ws(RCC_MIXER_DIVIDER_CTRL, 8'h06);
		cmp({chain_cfg_out.mixer_active, chain_cfg_out.mixer_mode}, 8'h0);
		foreach (pv[k]) begin
			@(posedge mclk_in);
			other_features_on_in <= pf[k];
			ws(RCC_POWER_BYPASS_CTRL, pv[k]);
			cmp({chain_cfg_out.chain_off, chain_cfg_out.chan_a_midcode,
				chain_cfg_out.chan_b_midcode}, pe[k]);
			rate(8'd20);
		end
		ws(RCC_POWER_BYPASS_CTRL, 8'h20);
		cmp(chain_cfg_out.bypass, 1'b0);
		ws(RCC_POWER_BYPASS_CTRL, 8'h60);
		cmp(chain_cfg_out.bypass, 1'b1);
		ws(RCC_POWER_BYPASS_CTRL, 8'h00);
		// block disables set but global on: they must be ignored
		wr(RCC_MIXER_DIVIDER_CTRL, 8'h60);
		wr(RCC_ALIGN_DISABLE, 8'h0e);
		@(posedge mclk_in);
		align_pin_in <= 1'b1;
		pulse(4'hf);
		cmp({mixer_phase_out, divider_phase_out}, 8'h5);
		@(posedge mclk_in);
		align_pin_in <= 1'b0;
		wr(RCC_ALIGN_SOURCE_SELECT, 8'h10);
		wr(RCC_MIXER_DIVIDER_CTRL, 8'h10);
		wr(RCC_ALIGN_SOFT_TRIGGER, 8'h10);
		pulse(4'hf);
		cmp({mixer_phase_out, divider_phase_out}, 8'h2);
		wr(RCC_ALIGN_SOFT_TRIGGER, 8'h00);
		wr(RCC_ALIGN_DISABLE, 8'h13);
		ws(RCC_MIXER_DIVIDER_CTRL, 8'h08);
		cmp(mixer_phase_out, 2'h2);
		ws(RCC_MIXER_DIVIDER_CTRL, 8'h88);
		cmp({mixer_phase_out, divider_phase_out}, 8'h5);
		ws(RCC_MIXER_DIVIDER_CTRL, 8'h00);
		ws(RCC_MIXER_DIVIDER_CTRL, 8'h08);
		cmp({mixer_phase_out, divider_phase_out}, 8'h7);
		wr(RCC_ALIGN_DISABLE, 8'h1e);
		wr(RCC_ALIGN_SOURCE_SELECT, 8'h01);
		wr(RCC_MIXER_DIVIDER_CTRL, 8'h20);
		wr(RCC_ALIGN_SOFT_TRIGGER, 8'h01);
		pulse(4'h1);
		cmp(mixer_phase_out, 2'h2);
		wr(RCC_ALIGN_SOURCE_SELECT, 8'h00);
		@(posedge mclk_in);
		align_pin_in <= 1'b1;
		pulse(4'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** verilog/rcc_pkg.sv ***
package rcc_pkg;

	localparam int unsigned RCC_ADDR_W = 9;
	localparam int unsigned RCC_DATA_W = 8;

	// register offsets
	localparam logic [8:0] RCC_FILTER_LOOPBACK_CTRL = 9'h165;
	localparam logic [8:0] RCC_MIXER_DIVIDER_CTRL   = 9'h166;
	localparam logic [8:0] RCC_POWER_BYPASS_CTRL    = 9'h167;
	localparam logic [8:0] RCC_ALIGN_DISABLE        = 9'h168;
	localparam logic [8:0] RCC_ALIGN_SOURCE_SELECT  = 9'h169;
	localparam logic [8:0] RCC_ALIGN_SOFT_TRIGGER   = 9'h16a;
	localparam logic [8:0] RCC_CHAIN_STATUS         = 9'h1ff;

	localparam logic [7:0] RCC_REG_RESET = 8'h00;

	// rx_filter_loopback_ctrl fields
	localparam int unsigned RCC_DECIM_FILTER_ON   = 0;
	localparam int unsigned RCC_DECIM_FILTER_GATE = 1;
	localparam int unsigned RCC_CHAN_A_HIGHPASS   = 2;
	localparam int unsigned RCC_CHAN_B_HIGHPASS   = 3;
	localparam int unsigned RCC_LOOPBACK_ON       = 6;
	localparam int unsigned RCC_LOOPBACK_GATE     = 7;

	// rx_mixer_divider_ctrl fields
	localparam int unsigned RCC_COARSE_MIXER_ON     = 0;
	localparam int unsigned RCC_COARSE_MIXER_SEL_LO = 1;
	localparam int unsigned RCC_MIXER_PHASE_STEP    = 3;
	localparam int unsigned RCC_MIXER_PHASE_VAL_LO  = 4;
	localparam int unsigned RCC_DIVIDER_PHASE_VALUE = 6;
	localparam int unsigned RCC_DIVIDER_PHASE_FLIP  = 7;

	// rx_power_bypass_ctrl fields
	localparam int unsigned RCC_CHAIN_OFF             = 0;
	localparam int unsigned RCC_CHAN_A_POWERDOWN_GATE = 1;
	localparam int unsigned RCC_CHAN_A_POWERDOWN      = 2;
	localparam int unsigned RCC_CHAN_B_POWERDOWN      = 3;
	localparam int unsigned RCC_CHAN_B_POWERDOWN_GATE = 4;
	localparam int unsigned RCC_CHAIN_BYPASS          = 5;
	localparam int unsigned RCC_CHAIN_BYPASS_GATE     = 6;

	// per-block order in align registers: bit index of each block, global at 4
	localparam int unsigned RCC_NUM_BLOCKS  = 4;
	localparam int unsigned RCC_BLK_MIXER   = 0;
	localparam int unsigned RCC_BLK_DIVIDER = 1;
	localparam int unsigned RCC_BLK_OFFSET  = 2;
	localparam int unsigned RCC_BLK_GAINPH  = 3;
	localparam int unsigned RCC_GLOBAL_BIT  = 4;

	typedef enum logic [1:0] {
		RCC_MIX_LOWPASS  = 2'b00,
		RCC_MIX_HALF_FS  = 2'b01,
		RCC_MIX_PLUS_Q   = 2'b10,
		RCC_MIX_MINUS_Q  = 2'b11
	} rcc_mix_mode_t;

	// one-cycle alignment pulses per receive block
	typedef struct packed {
		logic gainphase_corr;
		logic offset_corr;
		logic divider;
		logic mixer;
	} rcc_align_t;

	// effective chain configuration seen by the datapath
	typedef struct packed {
		logic          decim_active;
		logic          chan_a_highpass;
		logic          chan_b_highpass;
		logic          loopback_sel;
		logic          mixer_active;
		rcc_mix_mode_t mixer_mode;
		logic          chain_off;
		logic          chan_a_midcode;
		logic          chan_b_midcode;
		logic          bypass;
	} rcc_cfg_t;

endpackage

// *** verilog/rcc_rx_chain_control.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Decimation enable acts on both channels only with its gate; output clock halves.
// - Per-channel filter-mode bit: set gives high-pass, clear gives low-pass.
// - Loopback and its gate both set route transmit output into receive input.
// - Coarse mixer mode applies only when mixer enabled; 0 low,1 fs/2,2 +fs/4,3 -fs/4.
// - Step bit rising edge advances mixer phase by one when mixer alignment disabled.
// - Programmed mixer phase loads into mixer on alignment event when enabled.
// - Programmed divider phase loads into divider on alignment event.
// - Receive clock divider runs whenever decimation is active.
// - Flip bit rising edge inverts divider phase when divider alignment disabled.
// - Chain disable powers down both channels and holds output at mid-code.
// - Channel power-down needs its gate; output goes mid-code, output clock runs.
// - Without digital features, all four power-down bits must be set together.
// - Bypass with its gate passes both channel inputs straight to outputs.
// - Per-block alignment disables count only while global disable is set.
// - Global disable clear: rising edge of global source aligns all blocks.
// - Block source: pin when clear, soft trigger rising edge when set.
// - Global source: pin when clear, global soft trigger rising edge when set.
module rcc_rx_chain_control
	import rcc_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	// register port
	input  wire logic [RCC_ADDR_W-1:0] reg_addr_in,
	input  wire logic [RCC_DATA_W-1:0] reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic      [RCC_DATA_W-1:0] reg_rdata_out,
	// chain inputs
	input  wire logic                  align_pin_in,
	input  wire logic                  other_features_on_in,
	// chain control
	output rcc_cfg_t                   chain_cfg_out,
	output rcc_align_t                 align_pulse_out,
	output logic      [1:0]            mixer_phase_out,
	output logic                       divider_phase_out,
	output logic                       out_clk_en_out
);

	// register state
	logic [7:0] filt_ff, nxt_filt;
	logic [7:0] mixdiv_ff, nxt_mixdiv;
	logic [7:0] pwr_ff, nxt_pwr;
	logic [7:0] adis_ff, nxt_adis;
	logic [7:0] asrc_ff, nxt_asrc;
	logic [7:0] trig_ff, nxt_trig;
	logic [7:0] rdata_ff, nxt_rdata;

	// edge history
	logic [4:0] trig_prev_ff, nxt_trig_prev;
	logic       pin_prev_ff, nxt_pin_prev;
	logic       step_prev_ff, nxt_step_prev;
	logic       flip_prev_ff, nxt_flip_prev;

	// chain state
	logic [1:0] mix_phase_ff, nxt_mix_phase;
	logic       div_phase_ff, nxt_div_phase;
	logic       clk_en_ff, nxt_clk_en;
	rcc_cfg_t   cfg_ff, nxt_cfg;
	rcc_align_t align_ff, nxt_align;

	// combinational helpers
	logic                      pin_rise;
	logic [4:0]                soft_rise;
	logic                      global_evt;
	logic [RCC_NUM_BLOCKS-1:0] blk_evt;
	logic [RCC_NUM_BLOCKS-1:0] blk_align;
	logic [RCC_NUM_BLOCKS-1:0] blk_off;
	logic                      global_off;
	logic                      decim_on;
	logic                      mixer_on;
	logic                      feature_on;
	logic                      pd_a;
	logic                      pd_b;
	logic                      step_rise;
	logic                      flip_rise;

	assign global_off = adis_ff[RCC_GLOBAL_BIT];
	assign pin_rise   = align_pin_in & ~pin_prev_ff;
	assign soft_rise  = trig_ff[4:0] & ~trig_prev_ff;
	assign step_rise  = mixdiv_ff[RCC_MIXER_PHASE_STEP] & ~step_prev_ff;
	assign flip_rise  = mixdiv_ff[RCC_DIVIDER_PHASE_FLIP] & ~flip_prev_ff;

	assign global_evt = ~global_off & (asrc_ff[RCC_GLOBAL_BIT] ?
		soft_rise[RCC_GLOBAL_BIT] : pin_rise);

	// per-block alignment source and disable
	genvar gi;
	generate
		for (gi = 0; gi < RCC_NUM_BLOCKS; gi++) begin : g_blk
			// block disable only honoured while global alignment is off
			assign blk_off[gi]   = global_off & adis_ff[gi];
			assign blk_evt[gi]   = global_off & ~adis_ff[gi] &
				(asrc_ff[gi] ? soft_rise[gi] : pin_rise);
			assign blk_align[gi] = global_evt | blk_evt[gi];
		end
	endgenerate

	assign decim_on   = filt_ff[RCC_DECIM_FILTER_ON] & filt_ff[RCC_DECIM_FILTER_GATE];
	assign mixer_on   = mixdiv_ff[RCC_COARSE_MIXER_ON];
	assign feature_on = decim_on | mixer_on | other_features_on_in;

	// power-down qualification
	always_comb begin
		pd_a = 1'b0;
		pd_b = 1'b0;
		if (feature_on) begin
			pd_a = pwr_ff[RCC_CHAN_A_POWERDOWN] & pwr_ff[RCC_CHAN_A_POWERDOWN_GATE];
			pd_b = pwr_ff[RCC_CHAN_B_POWERDOWN] & pwr_ff[RCC_CHAN_B_POWERDOWN_GATE];
		end else begin
			// default mode only honours power-down with all four bits set
			pd_a = pwr_ff[RCC_CHAN_A_POWERDOWN] & pwr_ff[RCC_CHAN_A_POWERDOWN_GATE] &
				pwr_ff[RCC_CHAN_B_POWERDOWN] & pwr_ff[RCC_CHAN_B_POWERDOWN_GATE];
			pd_b = pd_a;
		end
	end

	// register file next state
	always_comb begin
		nxt_filt   = filt_ff;
		nxt_mixdiv = mixdiv_ff;
		nxt_pwr    = pwr_ff;
		nxt_adis   = adis_ff;
		nxt_asrc   = asrc_ff;
		nxt_trig   = trig_ff;
		nxt_rdata  = 8'h00;
		if (reg_wr_in) begin
			case (reg_addr_in)
				RCC_FILTER_LOOPBACK_CTRL: nxt_filt   = reg_wdata_in & 8'hcf;
				RCC_MIXER_DIVIDER_CTRL:   nxt_mixdiv = reg_wdata_in;
				RCC_POWER_BYPASS_CTRL:    nxt_pwr    = reg_wdata_in & 8'h7f;
				RCC_ALIGN_DISABLE:        nxt_adis   = reg_wdata_in & 8'h1f;
				RCC_ALIGN_SOURCE_SELECT:  nxt_asrc   = reg_wdata_in & 8'h1f;
				RCC_ALIGN_SOFT_TRIGGER:   nxt_trig   = reg_wdata_in & 8'h1f;
				default: begin
				end
			endcase
		end
		// unmapped reads return zero; read data valid only the next cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				RCC_FILTER_LOOPBACK_CTRL: nxt_rdata = filt_ff;
				RCC_MIXER_DIVIDER_CTRL:   nxt_rdata = mixdiv_ff;
				RCC_POWER_BYPASS_CTRL:    nxt_rdata = pwr_ff;
				RCC_ALIGN_DISABLE:        nxt_rdata = adis_ff;
				RCC_ALIGN_SOURCE_SELECT:  nxt_rdata = asrc_ff;
				RCC_ALIGN_SOFT_TRIGGER:   nxt_rdata = trig_ff;
				RCC_CHAIN_STATUS:         nxt_rdata = {1'b0, cfg_ff.chain_off,
					cfg_ff.chan_b_midcode, cfg_ff.chan_a_midcode,
					cfg_ff.decim_active, div_phase_ff, mix_phase_ff};
				default:                  nxt_rdata = 8'h00;
			endcase
		end
	end

	// chain next state
	always_comb begin
		nxt_trig_prev = trig_ff[4:0];
		nxt_pin_prev  = align_pin_in;
		// software must drop and raise a trigger again to get another step
		nxt_step_prev = mixdiv_ff[RCC_MIXER_PHASE_STEP];
		nxt_flip_prev = mixdiv_ff[RCC_DIVIDER_PHASE_FLIP];

		// mixer phase advances one step per cycle while the mixer runs
		nxt_mix_phase = mix_phase_ff;
		if (mixer_on) begin
			nxt_mix_phase = mix_phase_ff + 2'd1;
		end
		if (blk_align[RCC_BLK_MIXER]) begin
			nxt_mix_phase = mixdiv_ff[RCC_MIXER_PHASE_VAL_LO +: 2];
		end else if (step_rise && blk_off[RCC_BLK_MIXER]) begin
			nxt_mix_phase = nxt_mix_phase + 2'd1;
		end

		// divide-by-two: phase toggles each cycle while decimating
		nxt_div_phase = div_phase_ff;
		if (decim_on) begin
			nxt_div_phase = ~div_phase_ff;
		end
		if (blk_align[RCC_BLK_DIVIDER]) begin
			nxt_div_phase = mixdiv_ff[RCC_DIVIDER_PHASE_VALUE];
		end else if (flip_rise && blk_off[RCC_BLK_DIVIDER]) begin
			nxt_div_phase = ~nxt_div_phase;
		end
		// half-rate output clock enable when decimating, else every cycle
		nxt_clk_en = decim_on ? nxt_div_phase : 1'b1;

		nxt_align.mixer          = blk_align[RCC_BLK_MIXER];
		nxt_align.divider        = blk_align[RCC_BLK_DIVIDER];
		nxt_align.offset_corr    = blk_align[RCC_BLK_OFFSET];
		nxt_align.gainphase_corr = blk_align[RCC_BLK_GAINPH];

		nxt_cfg.decim_active    = decim_on;
		nxt_cfg.chan_a_highpass = filt_ff[RCC_CHAN_A_HIGHPASS];
		nxt_cfg.chan_b_highpass = filt_ff[RCC_CHAN_B_HIGHPASS];
		nxt_cfg.loopback_sel    = filt_ff[RCC_LOOPBACK_ON] & filt_ff[RCC_LOOPBACK_GATE];
		nxt_cfg.mixer_active    = mixer_on;
		// mode is forced to plain low-pass while the mixer is off
		nxt_cfg.mixer_mode      = mixer_on ?
			rcc_mix_mode_t'(mixdiv_ff[RCC_COARSE_MIXER_SEL_LO +: 2]) : RCC_MIX_LOWPASS;
		nxt_cfg.chain_off       = pwr_ff[RCC_CHAIN_OFF];
		nxt_cfg.chan_a_midcode  = pwr_ff[RCC_CHAIN_OFF] | pd_a;
		nxt_cfg.chan_b_midcode  = pwr_ff[RCC_CHAIN_OFF] | pd_b;
		nxt_cfg.bypass          = pwr_ff[RCC_CHAIN_BYPASS] & pwr_ff[RCC_CHAIN_BYPASS_GATE];
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			filt_ff      <= RCC_REG_RESET;
			mixdiv_ff    <= RCC_REG_RESET;
			pwr_ff       <= RCC_REG_RESET;
			adis_ff      <= RCC_REG_RESET;
			asrc_ff      <= RCC_REG_RESET;
			trig_ff      <= RCC_REG_RESET;
			rdata_ff     <= RCC_REG_RESET;
			trig_prev_ff <= 5'h00;
			pin_prev_ff  <= 1'b0;
			step_prev_ff <= 1'b0;
			flip_prev_ff <= 1'b0;
			mix_phase_ff <= 2'h0;
			div_phase_ff <= 1'b0;
			clk_en_ff    <= 1'b0;
			cfg_ff       <= '0;
			align_ff     <= '0;
		end else begin
			filt_ff      <= nxt_filt;
			mixdiv_ff    <= nxt_mixdiv;
			pwr_ff       <= nxt_pwr;
			adis_ff      <= nxt_adis;
			asrc_ff      <= nxt_asrc;
			trig_ff      <= nxt_trig;
			rdata_ff     <= nxt_rdata;
			trig_prev_ff <= nxt_trig_prev;
			pin_prev_ff  <= nxt_pin_prev;
			step_prev_ff <= nxt_step_prev;
			flip_prev_ff <= nxt_flip_prev;
			mix_phase_ff <= nxt_mix_phase;
			div_phase_ff <= nxt_div_phase;
			clk_en_ff    <= nxt_clk_en;
			cfg_ff       <= nxt_cfg;
			align_ff     <= nxt_align;
		end
	end

	assign reg_rdata_out     = rdata_ff;
	assign chain_cfg_out     = cfg_ff;
	assign align_pulse_out   = align_ff;
	assign mixer_phase_out   = mix_phase_ff;
	assign divider_phase_out = div_phase_ff;
	assign out_clk_en_out    = clk_en_ff;

endmodule

`default_nettype wire
